// ---- logic/cfm_cfg.svh ----
`ifndef CFM_CFG_SVH
`define CFM_CFG_SVH
// Register byte offsets
`define CFM_A_MODE 8'h00
`define CFM_A_CFG 8'h04
`define CFM_A_LED 8'h08
`define CFM_A_STAT 8'h0C
// operating_mode_select codes
`define CFM_M_SHUT 3'h0
`define CFM_M_DIS 3'h1
`define CFM_M_PRE 3'h2
`define CFM_M_CHG 3'h3
`define CFM_M_TORCH 3'h4
`define CFM_M_PWM 3'h5
`define CFM_M_FLASH 3'h6
`define CFM_MASK_FN 2'h1
// Field positions
`define CFM_F_MODE 0
`define CFM_F_POST 4
`define CFM_F_PCL 0
`define CFM_F_MRED 4
`define CFM_F_BLT 8
`define CFM_F_MFN 12
`define CFM_F_KEEP 16
`define CFM_F_BFORCE 17
`define CFM_F_BACKOFF 18
`define CFM_F_RAMPDN 19
`define CFM_F_LEVEL 0
`define CFM_F_DUTY 8
`define CFM_F_FDUR 16
`define CFM_F_RED 8
`define CFM_F_FLAG 16
// Reset values
`define CFM_RST_PCL 3'h4
`define CFM_RST_MRED 3'h2
`define CFM_RST_FDUR 8'h10
// Timing
`define CFM_CLK_NS 5
`define CFM_RAMP_NS 1000
`define CFM_PWM_SLOT_NS 2000
`define CFM_FLASH_STEP_NS 1000000
`endif

// ---- logic/cfm_pkg.sv ----
package cfm_pkg;
  typedef enum logic [3:0] {
    ST_SHUT, ST_PREDIS, ST_DISCH, ST_PCDIS, ST_PCCHG, ST_CHG, ST_TORCH, ST_PWM, ST_FLASH
  } cfm_state_t;

  // Analog comparator levels, asynchronous to mclk_i
  typedef struct packed {
    logic vdcdc_hi;
    logic vdcdc_lo;
    logic vcap_over;
    logic vcap_flat;
    logic vcap_pc_lo;
    logic vcap_full;
    logic temp_over;
    logic temp_cool;
    logic vin_low;
    logic bb_lim;
    logic cb_lim;
    logic mask_pin;
  } cfm_sense_t;

  typedef struct packed {
    logic bb_en;
    logic cb_en;
    logic dis_en;
    logic pc_sw;
    logic chg_en;
    logic keep_en;
    logic bal_en;
    logic led_en;
    logic [7:0] led_level;
    logic [2:0] bb_limit;
    logic [1:0] regime;
  } cfm_ctrl_t;

  typedef struct packed {
    cfm_sense_t sync1;
    cfm_sense_t sync2;
    cfm_state_t st;
    logic [2:0] mode;
    logic [1:0] post;
    logic [2:0] pcl;
    logic [2:0] mred;
    logic [2:0] blt;
    logic [1:0] mfn;
    logic keep;
    logic bforce;
    logic backoff;
    logic rampdn;
    logic [7:0] level;
    logic [3:0] duty;
    logic [7:0] fdur;
    logic [7:0] red_level;
    logic red_flag;
    logic [7:0] led;
    logic [2:0] lim;
    logic hot;
    logic cb_off;
    logic ramping;
    logic [7:0] ftime;
    logic [19:0] fpre;
    logic [7:0] rpre;
    logic [8:0] ppre;
    logic [3:0] phase;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic rdy;
    cfm_ctrl_t ctrl;
  } cfm_regs_t;
endpackage

// ---- logic/cfm_mode_ctrl.sv ----
`timescale 1ns/1ps
`include "cfm_cfg.svh"

// Notes on behaviour
// - Shutdown-keep holds capacitor charge, balancer off unless forced.
// - Shutdown entry discharges first while boost output above 5.35V, until below 5.3V.
// - Shutdown-discharge mode bleeds the capacitor through the resistor path.
// - Pre-charge first bleeds to battery minus 0.3V, then charges to battery.
// - Capacitor above 5.5V is discharged in every mode.
// - Over-temperature suspends pre-charge and charge; resumes below hysteresis point.
// - Torch and PWM drive LED at set level; PWM gates by duty.
// - Torch or PWM with maintain set tops capacitor up to target.
// - Flash length is bounded by the programmed timeout.
// - Capacitor below 2.55V during flash stops the capacitor boost.
// - Flash end loads the mode from the post-flash selection.
// - Flash regime: battery alone, capacitor adds remainder, or both limited.
// - Backoff ramps LED down until capacitor boost leaves limit; records result.
// - Mask function with primary limit zero runs flash from capacitor only.
// - Battery low in flash lowers the primary limit step by step.
// - Battery threshold zero disables that reduction.
// - Mask high in flash cuts primary limit at once; battery boost off if negative.
// - Mask release ramps primary limit back to programmed value.
// - Continuous rampdown lowers LED current throughout flash.
// - Balancer runs in charging and discharge states; flash, shutdown only forced.
module cfm_mode_ctrl
  import cfm_pkg::*;
#(
  parameter int unsigned FLASH_STEP_CYC = `CFM_FLASH_STEP_NS / `CFM_CLK_NS
)(
  // Clock, reset, enable
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // Comparators and converter controls
  input wire cfm_sense_t sense_i,
  output cfm_ctrl_t ctrl_o
);
  localparam int unsigned RAMP_CYC = (`CFM_RAMP_NS + `CFM_CLK_NS - 1) / `CFM_CLK_NS;
  localparam int unsigned PWM_CYC = (`CFM_PWM_SLOT_NS + `CFM_CLK_NS - 1) / `CFM_CLK_NS;

  cfm_regs_t r;
  cfm_regs_t n;
  cfm_sense_t s;
  logic rtick;
  logic fend;
  logic masked;
  logic flash;
  logic tp;

  function automatic logic [31:0] fld(input logic [31:0] v, input int pos, input int w);
    fld = (v >> pos) & ((32'h0000_0001 << w) - 32'h0000_0001);
  endfunction

  assign s = r.sync2;
  assign hreadyout_o = r.rdy;
  assign hresp_o = 1'b0;
  assign hrdata_o = r.rdata;
  assign ctrl_o = r.ctrl;

  always_comb
  begin
    n = r;
    n.sync1 = sense_i;
    n.sync2 = r.sync1;
    n.rdy = 1'b1;
    rtick = (r.rpre == 8'(RAMP_CYC - 1));
    n.rpre = rtick ? 8'h00 : r.rpre + 8'h01;
    // Write data phase follows the address phase latched last cycle
    n.wr_pend = hsel_i && htrans_i[1] && hready_i && hwrite_i;
    n.wr_addr = haddr_i[7:0];
    if (r.wr_pend)
    begin
      unique case (r.wr_addr)
        `CFM_A_MODE:
        begin
          n.mode = 3'(fld(hwdata_i, `CFM_F_MODE, 3));
          n.post = 2'(fld(hwdata_i, `CFM_F_POST, 2));
        end
        `CFM_A_CFG:
        begin
          n.pcl = 3'(fld(hwdata_i, `CFM_F_PCL, 3));
          n.mred = 3'(fld(hwdata_i, `CFM_F_MRED, 3));
          n.blt = 3'(fld(hwdata_i, `CFM_F_BLT, 3));
          n.mfn = 2'(fld(hwdata_i, `CFM_F_MFN, 2));
          n.keep = hwdata_i[`CFM_F_KEEP];
          n.bforce = hwdata_i[`CFM_F_BFORCE];
          n.backoff = hwdata_i[`CFM_F_BACKOFF];
          n.rampdn = hwdata_i[`CFM_F_RAMPDN];
        end
        `CFM_A_LED:
        begin
          n.level = 8'(fld(hwdata_i, `CFM_F_LEVEL, 8));
          n.duty = 4'(fld(hwdata_i, `CFM_F_DUTY, 4));
          n.fdur = 8'(fld(hwdata_i, `CFM_F_FDUR, 8));
        end
        `CFM_A_STAT:
          if (hwdata_i[`CFM_F_FLAG])
            n.red_flag = 1'b0;
        default:
          n.red_flag = n.red_flag;
      endcase
    end
    // Over-temperature latch with hysteresis
    if (s.temp_over)
      n.hot = 1'b1;
    else if (s.temp_cool)
      n.hot = 1'b0;
    // Flash timeout; hardware mode update wins over a same-cycle write
    fend = 1'b0;
    if (r.st == ST_FLASH)
    begin
      n.fpre = (r.fpre == 20'(FLASH_STEP_CYC - 1)) ? 20'h00000 : r.fpre + 20'h00001;
      if (r.fpre == 20'(FLASH_STEP_CYC - 1))
      begin
        n.ftime = r.ftime + 8'h01;
        if (r.ftime >= r.fdur)
          fend = 1'b1;
      end
      if (fend)
        n.mode = {1'b0, r.post};
    end
    // Mode decode into one state
    unique case (n.mode)
      `CFM_M_SHUT:
        if (r.st == ST_PREDIS)
          n.st = s.vdcdc_lo ? ST_SHUT : ST_PREDIS;
        else if (r.st != ST_SHUT)
          n.st = s.vdcdc_hi ? ST_PREDIS : ST_SHUT;
      `CFM_M_DIS:
        n.st = ST_DISCH;
      `CFM_M_PRE:
        if (r.st == ST_PCDIS)
          n.st = s.vcap_pc_lo ? ST_PCCHG : ST_PCDIS;
        else if (r.st != ST_PCCHG)
          n.st = ST_PCDIS;
      `CFM_M_CHG:
        n.st = ST_CHG;
      `CFM_M_TORCH:
        n.st = ST_TORCH;
      `CFM_M_PWM:
        n.st = ST_PWM;
      `CFM_M_FLASH:
        n.st = ST_FLASH;
      default:
        n.st = ST_SHUT;
    endcase
    // PWM slot counter
    n.ppre = (r.ppre == 9'(PWM_CYC - 1)) ? 9'h000 : r.ppre + 9'h001;
    if (r.ppre == 9'(PWM_CYC - 1))
      n.phase = r.phase + 4'h1;
    masked = (r.mfn == `CFM_MASK_FN) && s.mask_pin;
    if (n.st == ST_FLASH && r.st != ST_FLASH)
    begin
      n.ftime = 8'h00;
      n.fpre = 20'h00000;
      n.led = r.level;
      n.lim = r.pcl;
      n.cb_off = 1'b0;
      n.ramping = 1'b0;
    end
    else if (r.st == ST_FLASH)
    begin
      if (s.vcap_flat)
        n.cb_off = 1'b1;
      if (masked)
        n.lim = (r.mred > r.pcl) ? 3'h0 : r.pcl - r.mred;
      else if (r.lim > r.pcl)
        n.lim = r.pcl;
      else if (rtick && s.vin_low && r.blt != 3'h0)
        n.lim = (r.lim > 3'h1) ? r.lim - 3'h1 : r.lim;
      else if (rtick && r.lim < r.pcl)
        n.lim = r.lim + 3'h1;
      if (r.backoff && s.bb_lim && s.cb_lim)
        n.ramping = 1'b1;
      if (rtick && r.led != 8'h00 && (r.rampdn || (r.backoff && s.bb_lim && s.cb_lim)))
        n.led = r.led - 8'h01;
      if (r.ramping && !s.cb_lim)
      begin
        n.ramping = 1'b0;
        n.red_level = r.led;
        n.red_flag = 1'b1;
      end
    end
    // Converter controls, registered with the state they belong to
    flash = (n.st == ST_FLASH);
    tp = (n.st == ST_TORCH) || (n.st == ST_PWM);
    n.ctrl.bb_en = tp || (n.st == ST_CHG && !n.hot) || (flash && n.lim != 3'h0);
    n.ctrl.cb_en = flash && !n.cb_off && (s.bb_lim || n.lim == 3'h0);
    n.ctrl.dis_en = (n.st == ST_DISCH) || (n.st == ST_PCDIS) || (n.st == ST_PREDIS) || s.vcap_over;
    n.ctrl.pc_sw = (n.st == ST_PCCHG) && !n.hot;
    n.ctrl.chg_en = (n.st == ST_CHG) && !n.hot;
    n.ctrl.keep_en = tp && n.keep && !s.vcap_full;
    n.ctrl.bal_en = (n.st == ST_PCDIS) || (n.st == ST_PCCHG) || (n.st == ST_CHG) || (n.st == ST_DISCH)
      || (n.st == ST_PREDIS) || (tp && n.keep) || ((flash || n.st == ST_SHUT) && n.bforce);
    n.ctrl.led_en = (n.st == ST_TORCH) || flash || (n.st == ST_PWM && n.phase <= n.duty);
    n.ctrl.led_level = flash ? n.led : tp ? n.level : 8'h00;
    n.ctrl.bb_limit = flash ? n.lim : n.pcl;
    n.ctrl.regime = !flash ? 2'h0 : !s.bb_lim ? 2'h1 : !s.cb_lim ? 2'h2 : 2'h3;
    // Read data captured in the address phase, after any write landing now
    if (hsel_i && htrans_i[1] && hready_i && !hwrite_i)
    begin
      unique case (haddr_i[7:0])
        `CFM_A_MODE:
          n.rdata = (32'(n.mode) << `CFM_F_MODE) | (32'(n.post) << `CFM_F_POST);
        `CFM_A_CFG:
          n.rdata = (32'(n.pcl) << `CFM_F_PCL) | (32'(n.mred) << `CFM_F_MRED) | (32'(n.blt) << `CFM_F_BLT)
            | (32'(n.mfn) << `CFM_F_MFN) | (32'(n.keep) << `CFM_F_KEEP) | (32'(n.bforce) << `CFM_F_BFORCE)
            | (32'(n.backoff) << `CFM_F_BACKOFF) | (32'(n.rampdn) << `CFM_F_RAMPDN);
        `CFM_A_LED:
          n.rdata = (32'(n.level) << `CFM_F_LEVEL) | (32'(n.duty) << `CFM_F_DUTY) | (32'(n.fdur) << `CFM_F_FDUR);
        `CFM_A_STAT:
          n.rdata = 32'(n.st) | (32'(n.hot) << 4) | (32'(n.cb_off) << 5) | (32'(n.ctrl.regime) << 6)
            | (32'(n.red_level) << `CFM_F_RED) | (32'(n.red_flag) << `CFM_F_FLAG);
        default:
          n.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      r <= '0;
      r.pcl <= `CFM_RST_PCL;
      r.mred <= `CFM_RST_MRED;
      r.fdur <= `CFM_RST_FDUR;
    end
    else if (ce_i)
    begin
      r <= n;
    end
  end

  default clocking dcb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  a_shut_bal_off: assert property (r.st == ST_SHUT && !r.bforce |-> !ctrl_o.bal_en)
    else $error("balancer on in shutdown");
  a_predis_entry: assert property (ce_i && r.st != ST_SHUT && r.st != ST_PREDIS
    && n.mode == `CFM_M_SHUT && s.vdcdc_hi |=> r.st == ST_PREDIS && ctrl_o.dis_en)
    else $error("no discharge before shutdown");
  a_disch_path: assert property (r.st == ST_DISCH |-> ctrl_o.dis_en && ctrl_o.bal_en)
    else $error("discharge path off");
  a_pc_order: assert property (ce_i && r.st == ST_PCDIS && !s.vcap_pc_lo |=> r.st != ST_PCCHG)
    else $error("pre-charge skipped discharge");
  a_ovp_dis: assert property (ce_i && s.vcap_over |=> ctrl_o.dis_en)
    else $error("overvoltage not discharged");
  a_hot_hold: assert property (r.hot |-> !ctrl_o.chg_en && !ctrl_o.pc_sw)
    else $error("charging while hot");
  a_torch_lvl: assert property (r.st == ST_TORCH |-> ctrl_o.bb_en && ctrl_o.led_en
    && ctrl_o.led_level == r.level)
    else $error("torch drive wrong");
  a_flash_post: assert property (ce_i && fend |=> r.mode == {1'b0, $past(r.post)})
    else $error("post-flash mode wrong");
  a_flat_stop: assert property (r.cb_off |-> !ctrl_o.cb_en)
    else $error("cap boost on below 2.55V");
  a_mask_zero: assert property (r.st == ST_FLASH && r.lim == 3'h0 |-> !ctrl_o.bb_en)
    else $error("battery boost on at zero limit");

  c_flash_end: cover property (ce_i && fend);
  c_mask_flash: cover property (r.st == ST_FLASH && s.mask_pin && r.mfn == `CFM_MASK_FN);
  c_backoff: cover property (!r.red_flag ##1 r.red_flag);
  c_predis: cover property (r.st == ST_PREDIS ##[1:20] r.st == ST_SHUT);
endmodule

// ---- verif/cfm_plant.sv ----
`timescale 1ns/1ps
module cfm_plant
  import cfm_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Controls and forced levels
  input wire cfm_ctrl_t ctrl_i,
  input wire cfm_sense_t knob_i,
  // Comparator levels
  output cfm_sense_t sense_o
);
  int vcap;
  // Crude capacitor: one unit a cycle, so thresholds are reached quickly
  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      vcap <= 0;
    else if (ctrl_i.dis_en && vcap > 0)
      vcap <= vcap - 1;
    else if ((ctrl_i.pc_sw || ctrl_i.chg_en || ctrl_i.keep_en) && vcap < 100)
      vcap <= vcap + 1;
  end
  always_comb
  begin
    sense_o = knob_i; // Levels not overridden below come straight from the knobs
    sense_o.vdcdc_lo = !knob_i.vdcdc_hi;
    sense_o.vcap_pc_lo = knob_i.vcap_pc_lo || vcap < 40;
    sense_o.vcap_full = knob_i.vcap_full || vcap >= 80;
  end
endmodule

// ---- verif/cfm_mode_ctrl_tb_top.sv ----
`timescale 1ns/1ps
`include "cfm_cfg.svh"
module cfm_mode_ctrl_tb_top;
  import cfm_pkg::*;
  typedef struct packed {logic [2:0] m; logic [3:0] st; logic bal; logic dis;} cfm_row_t;
  localparam int STEP = 20;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic [31:0] hrdata;
  logic [31:0] q;
  logic [7:0] v;
  cfm_sense_t knob = '0;
  cfm_sense_t sense;
  cfm_ctrl_t ctrl;
  int bad_count = 0;
  int checks = 0;
  int n;
  time t0;
  // Mode code, state index, balancer, resistor bleed
  cfm_row_t rows [7] = '{'{3'h1, 4'h2, 1'b1, 1'b1}, '{3'h2, 4'h4, 1'b1, 1'b0}, '{3'h3, 4'h5, 1'b1, 1'b0},
    '{3'h4, 4'h6, 1'b0, 1'b0}, '{3'h5, 4'h7, 1'b0, 1'b0}, '{3'h7, 4'h0, 1'b0, 1'b0}, '{3'h0, 4'h0, 1'b0, 1'b0}};

  cfm_mode_ctrl #(.FLASH_STEP_CYC(STEP)) cfm_mode_ctrl_i (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hready_i(hreadyout), .hwdata_i(hwdata), .hreadyout_o(hreadyout), .hresp_o(), .hrdata_o(hrdata),
    .sense_i(sense), .ctrl_o(ctrl));
  cfm_plant cfm_plant_i (.mclk_i(mclk_i), .rst_i(rst_i), .ctrl_i(ctrl), .knob_i(knob), .sense_o(sense));

  initial
  begin
    forever #2.5 mclk_i = ~mclk_i;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic give_up;
    bad_count++;
    $display("wrong value at %0t: wait ran out", $time);
    tally_and_finish();
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_rdy;
    int k;
    k = 0;
    do
    begin
      @(posedge mclk_i);
      k++;
    end
    while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50)
      give_up();
  endtask
  // Address phase held until ready, then data phase held until ready
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    int k;
    k = 0;
    ahb(1'b0, a, 32'h0);
    while ((q & m) !== e && k < 400)
    begin
      ahb(1'b0, a, 32'h0);
      k++;
    end
    if (k >= 400)
      give_up();
    else
      chk(q & m, e);
  endtask
  // Comparator change reaches the controls on the third edge
  task automatic settle;
    repeat (4) @(posedge mclk_i);
    #1;
  endtask
  task automatic ctl_wait(input int lim);
    for (n = 0; n < lim && ctrl.bb_limit === 3'h4; n++)
      @(posedge mclk_i);
    #1;
  endtask

  initial
  begin
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    poll(`CFM_A_MODE, 32'hFFFFFFFF, 32'h0);
    poll(`CFM_A_CFG, 32'hFFFFFFFF, 32'h24);
    poll(`CFM_A_LED, 32'hFFFFFFFF, 32'h00100000);
    wr(8'h10, 32'hFFFFFFFF);
    poll(8'h10, 32'hFFFFFFFF, 32'h0);
    $display("test reset done");
    wr(`CFM_A_LED, 32'h00030A40);
    for (int i = 0; i < 7; i++)
    begin
      wr(`CFM_A_MODE, {29'h0, rows[i].m});
      poll(`CFM_A_STAT, 32'hF, {28'h0, rows[i].st});
      chk(ctrl.bal_en, rows[i].bal);
      chk(ctrl.dis_en, rows[i].dis);
      chk(ctrl.pc_sw, rows[i].m == 3'h2);
    end
    $display("test mode table done");
    wr(`CFM_A_MODE, 32'h4);
    poll(`CFM_A_STAT, 32'hF, 32'h6);
    chk(ctrl.led_level, 8'h40);
    wr(`CFM_A_CFG, 32'h00010024);
    settle();
    chk(ctrl.bal_en, 1'b1);
    chk(ctrl.keep_en, 1'b1);
    wr(`CFM_A_MODE, 32'h5);
    poll(`CFM_A_STAT, 32'hF, 32'h7);
    n = 0;
    repeat (6400)
    begin
      @(negedge mclk_i);
      n += ctrl.led_en;
    end
    chk(n, 4400);
    // Plant capacitor has reached the target by now, so the top-up must have stopped
    chk(ctrl.keep_en, 1'b0);
    $display("test torch and pwm done");
    wr(`CFM_A_MODE, 32'h3);
    poll(`CFM_A_STAT, 32'hF, 32'h5);
    knob.temp_over <= 1'b1;
    poll(`CFM_A_STAT, 32'h10, 32'h10);
    chk(ctrl.chg_en, 1'b0);
    knob.temp_over <= 1'b0;
    knob.temp_cool <= 1'b1;
    poll(`CFM_A_STAT, 32'h10, 32'h0);
    chk(ctrl.chg_en, 1'b1);
    knob.temp_cool <= 1'b0;
    knob.vdcdc_hi <= 1'b1;
    // Comparator must be through the synchroniser before the mode write lands
    settle();
    wr(`CFM_A_MODE, 32'h0);
    poll(`CFM_A_STAT, 32'hF, 32'h1);
    chk(ctrl.dis_en, 1'b1);
    knob.vdcdc_hi <= 1'b0;
    poll(`CFM_A_STAT, 32'hF, 32'h0);
    knob.vcap_over <= 1'b1;
    settle();
    chk(ctrl.dis_en, 1'b1);
    knob.vcap_over <= 1'b0;
    $display("test charge and shutdown done");
    wr(`CFM_A_LED, 32'h00030040);
    for (int p = 0; p < 4; p++)
    begin
      wr(`CFM_A_MODE, 32'h6 | (p << 4));
      t0 = $time;
      poll(`CFM_A_STAT, 32'hF, 32'h8);
      poll(`CFM_A_MODE, 32'h7, p);
      n = int'(($time - t0) / 5);
      chk(n >= 75 && n <= 95, 1'b1);
    end
    $display("test flash end done");
    wr(`CFM_A_CFG, 32'h00001024);
    wr(`CFM_A_LED, 32'h00FF0040);
    wr(`CFM_A_MODE, 32'h6);
    poll(`CFM_A_STAT, 32'hF, 32'h8);
    settle();
    chk(ctrl.regime, 2'h1);
    knob.bb_lim <= 1'b1;
    settle();
    chk({ctrl.regime, ctrl.cb_en}, 3'h5);
    knob.cb_lim <= 1'b1;
    settle();
    chk(ctrl.regime, 2'h3);
    knob.cb_lim <= 1'b0;
    knob.mask_pin <= 1'b1;
    settle();
    chk(ctrl.bb_limit, 3'h2);
    knob.mask_pin <= 1'b0;
    settle();
    chk(ctrl.bb_limit !== 3'h4, 1'b1);
    for (n = 0; n < 1000 && ctrl.bb_limit !== 3'h4; n++)
      @(posedge mclk_i);
    chk(ctrl.bb_limit, 3'h4);
    knob.vin_low <= 1'b1;
    // Long enough to span at least one ramp tick
    ctl_wait(300);
    chk(ctrl.bb_limit, 3'h4);
    wr(`CFM_A_CFG, 32'h00001324);
    ctl_wait(1000);
    chk(ctrl.bb_limit < 3'h4, 1'b1);
    knob.vin_low <= 1'b0;
    wr(`CFM_A_CFG, 32'h00001054);
    knob.mask_pin <= 1'b1;
    settle();
    chk(ctrl.bb_en, 1'b0);
    knob.mask_pin <= 1'b0;
    wr(`CFM_A_CFG, 32'h00041024);
    knob.cb_lim <= 1'b1;
    for (n = 0; n < 1000 && ctrl.led_level === 8'h40; n++)
      @(posedge mclk_i);
    knob.cb_lim <= 1'b0;
    poll(`CFM_A_STAT, 32'h10000, 32'h10000);
    chk(q[15:8] < 8'h40, 1'b1);
    wr(`CFM_A_CFG, 32'h00081024);
    v = ctrl.led_level;
    for (n = 0; n < 1000 && ctrl.led_level === v; n++)
      @(posedge mclk_i);
    #1;
    chk(ctrl.led_level < v, 1'b1);
    // Clock enable low must freeze the rampdown over more than two ramp ticks
    ce <= 1'b0;
    v = ctrl.led_level;
    repeat (450) @(posedge mclk_i);
    #1;
    chk(ctrl.led_level, v);
    ce <= 1'b1;
    knob.vcap_flat <= 1'b1;
    settle();
    chk(ctrl.cb_en, 1'b0);
    poll(`CFM_A_STAT, 32'h20, 32'h20);
    $display("test flash regimes done");
    tally_and_finish();
  end
endmodule
